/* File: include/tfdc_pkg.sv */
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package tfdc_pkg;
   localparam int NCH = 3;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_OP    [NCH] = '{8'h33, 8'h34, 8'h35};
   localparam logic [7:0] IDX_CEIL  [NCH] = '{8'h38, 8'h39, 8'h3a};
   localparam logic [7:0] IDX_LOW   [NCH] = '{8'h4e, 8'h50, 8'h52};
   localparam logic [7:0] IDX_HIGH  [NCH] = '{8'h4f, 8'h51, 8'h53};
   localparam logic [7:0] IDX_SPAN  [NCH] = '{8'h5f, 8'h60, 8'h61};
   localparam logic [7:0] IDX_FLOOR [NCH] = '{8'h64, 8'h65, 8'h66};
   localparam logic [7:0] IDX_CRIT  [NCH] = '{8'h6a, 8'h6b, 8'h6c};
   localparam logic [7:0] IDX_THR   [NCH] = '{8'h70, 8'h71, 8'h72};
   localparam logic [7:0] IDX_IDLE   = 8'h62;
   localparam logic [7:0] IDX_HYST_A = 8'h6d;
   localparam logic [7:0] IDX_HYST_B = 8'h6e;
   localparam logic [7:0] IDX_CTRL   = 8'h73;
   localparam logic [7:0] IDX_STAT   = 8'h74;
   // field positions
   localparam int SPAN_LSB = 4;
   localparam int HYST_HI_LSB = 4;
   localparam int HYST_LO_LSB = 0;
   localparam int IDLE_LSB = 5;
   localparam int CTRL_DYN_BIT = 0;
   localparam int STAT_LOW_LSB = 0;
   localparam int STAT_HIGH_LSB = 3;
   localparam int STAT_CRIT_LSB = 6;
   localparam int STAT_ON_LSB = 9;
   // duty arithmetic; spans are held as six times degrees
   localparam logic [7:0]  DUTY_FULL = 8'hff;
   localparam logic [7:0]  PWM_TOP   = 8'hfe;
   localparam logic [17:0] SLOPE_NUM = 18'h003fc;
   localparam logic [8:0]  SPAN_X6 [16] = '{
      9'h00c, 9'h00f, 9'h014, 9'h018, 9'h01e, 9'h028, 9'h030, 9'h03c,
      9'h050, 9'h060, 9'h078, 9'h0a0, 9'h0c0, 9'h0f0, 9'h140, 9'h1e0};
   // monitoring cycle: 125 ms at 10 MHz
   localparam int MON_PERIOD_US = 125000;
   localparam int CLK_MHZ = 10;
   localparam int MON_CYCLES = MON_PERIOD_US * CLK_MHZ;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] op;
      logic [7:0] low;
      logic [7:0] high;
      logic [7:0] crit;
      logic [7:0] thr;
      logic [7:0] floor;
      logic [7:0] ceil;
      logic [3:0] span;
      logic [3:0] hyst;
   } tfdc_chan_t;

   localparam tfdc_chan_t RST_CHAN = '{
      op: 8'ha4, low: 8'h01, high: 8'h7f, crit: 8'ha4, thr: 8'h5a,
      floor: 8'h80, ceil: 8'hff, span: 4'hc, hyst: 4'h4};
   localparam logic [7:0] RST_IDLE = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h01;
endpackage : tfdc_pkg

/* File: rtl/tfdc_top.sv */
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module tfdc_top #(
   parameter int ADDR_W     = 10,
   parameter int MON_CYCLES = tfdc_pkg::MON_CYCLES
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [7:0]        temp_remote1,
   input  wire logic [7:0]        temp_local,
   input  wire logic [7:0]        temp_remote2,
   output logic                   fan_out_1,
   output logic                   fan_out_2,
   output logic                   fan_out_3,
   output logic                   critical_active
);
   localparam int NCH = tfdc_pkg::NCH;
   localparam int CNT_W = $clog2(MON_CYCLES + 1);

   tfdc_pkg::tfdc_chan_t cfg [NCH];
   logic [7:0]        temp [NCH];
   logic [7:0]        idle_policy;
   logic [7:0]        ctrl;
   logic [NCH-1:0]    stat_low;
   logic [NCH-1:0]    stat_high;
   logic [NCH-1:0]    fan_on;
   logic [NCH-1:0]    crit_on;
   logic [NCH-1:0]    below_low;
   logic [NCH-1:0]    above_high;
   logic [NCH-1:0]    thr_dec;
   logic [NCH-1:0]    thr_inc;
   logic [7:0]        duty [NCH];
   logic [NCH-1:0]    pwm_q;
   logic [7:0]        pwm_cnt;
   logic [CNT_W-1:0]  mon_cnt;
   logic              tick;

   assign temp[0] = temp_remote1;
   assign temp[1] = temp_local;
   assign temp[2] = temp_remote2;

   // ---------------------------------------------------------------
   // axi4-lite write channel
   // ---------------------------------------------------------------
   logic              aw_full;
   logic              w_full;
   logic [7:0]        wr_idx;
   logic [7:0]        wr_data;
   logic              wr_lane;
   logic              do_write;
   logic              wr_hit;
   logic              we;
   logic              next_aw_full;
   logic              next_w_full;
   logic              next_bvalid;

   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign we = do_write && wr_lane;

   always_comb begin
      next_aw_full = aw_full;
      next_w_full = w_full;
      next_bvalid = s_axi_bvalid;
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         s_axi_bvalid <= next_bvalid;
         // one write in flight; ready drops until the answer is taken
         s_axi_awready <= !next_aw_full && !next_bvalid;
         s_axi_wready <= !next_w_full && !next_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_idx <= '0;
         wr_data <= '0;
         wr_lane <= 1'b0;
         s_axi_bresp <= tfdc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_idx <= s_axi_awaddr[9:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data <= s_axi_wdata[7:0];
            wr_lane <= s_axi_wstrb[0];
         end
         if (do_write) begin
            s_axi_bresp <= wr_hit ? tfdc_pkg::RESP_OKAY
                                  : tfdc_pkg::RESP_SLVERR;
         end
      end
   end

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic idx_mapped(input logic [7:0] idx);
      logic hit;
      hit = (idx == tfdc_pkg::IDX_IDLE) || (idx == tfdc_pkg::IDX_CTRL) ||
            (idx == tfdc_pkg::IDX_STAT) || (idx == tfdc_pkg::IDX_HYST_A) ||
            (idx == tfdc_pkg::IDX_HYST_B);
      for (int c = 0; c < NCH; c++) begin
         hit = hit || (idx == tfdc_pkg::IDX_OP[c]) ||
               (idx == tfdc_pkg::IDX_CEIL[c]) ||
               (idx == tfdc_pkg::IDX_LOW[c]) ||
               (idx == tfdc_pkg::IDX_HIGH[c]) ||
               (idx == tfdc_pkg::IDX_SPAN[c]) ||
               (idx == tfdc_pkg::IDX_FLOOR[c]) ||
               (idx == tfdc_pkg::IDX_CRIT[c]) ||
               (idx == tfdc_pkg::IDX_THR[c]);
      end
      return hit;
   endfunction : idx_mapped

   assign wr_hit = idx_mapped(wr_idx);

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int c = 0; c < NCH; c++) begin
            cfg[c] <= tfdc_pkg::RST_CHAN;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (tick && ctrl[tfdc_pkg::CTRL_DYN_BIT]) begin
               if (thr_dec[c] && cfg[c].thr != '0) begin
                  cfg[c].thr <= cfg[c].thr - 8'h01;
               end else if (thr_inc[c]) begin
                  cfg[c].thr <= cfg[c].thr + 8'h01;
               end
            end
            // software write wins over an automatic step
            if (we) begin
               if (wr_idx == tfdc_pkg::IDX_OP[c]) cfg[c].op <= wr_data;
               if (wr_idx == tfdc_pkg::IDX_LOW[c]) cfg[c].low <= wr_data;
               if (wr_idx == tfdc_pkg::IDX_HIGH[c]) cfg[c].high <= wr_data;
               if (wr_idx == tfdc_pkg::IDX_CRIT[c]) cfg[c].crit <= wr_data;
               if (wr_idx == tfdc_pkg::IDX_THR[c]) cfg[c].thr <= wr_data;
               if (wr_idx == tfdc_pkg::IDX_FLOOR[c]) cfg[c].floor <= wr_data;
               if (wr_idx == tfdc_pkg::IDX_CEIL[c]) cfg[c].ceil <= wr_data;
               if (wr_idx == tfdc_pkg::IDX_SPAN[c]) begin
                  cfg[c].span <= wr_data[tfdc_pkg::SPAN_LSB +: 4];
               end
            end
         end
         if (we && wr_idx == tfdc_pkg::IDX_HYST_A) begin
            cfg[0].hyst <= wr_data[tfdc_pkg::HYST_HI_LSB +: 4];
            cfg[1].hyst <= wr_data[tfdc_pkg::HYST_LO_LSB +: 4];
         end
         if (we && wr_idx == tfdc_pkg::IDX_HYST_B) begin
            cfg[2].hyst <= wr_data[tfdc_pkg::HYST_HI_LSB +: 4];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_policy <= tfdc_pkg::RST_IDLE;
         ctrl <= tfdc_pkg::RST_CTRL;
      end else if (we) begin
         if (wr_idx == tfdc_pkg::IDX_IDLE) idle_policy <= wr_data;
         if (wr_idx == tfdc_pkg::IDX_CTRL) ctrl <= wr_data;
      end
   end

   // sticky limit flags, write one to clear; a new event beats the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_low <= '0;
         stat_high <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            stat_low[c] <= below_low[c] || (stat_low[c] &&
               !(we && wr_idx == tfdc_pkg::IDX_STAT &&
                 wr_data[tfdc_pkg::STAT_LOW_LSB + c]));
            stat_high[c] <= above_high[c] || (stat_high[c] &&
               !(we && wr_idx == tfdc_pkg::IDX_STAT &&
                 wr_data[tfdc_pkg::STAT_HIGH_LSB + c]));
         end
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read channel
   // ---------------------------------------------------------------
   logic [7:0]  rd_idx;
   logic [31:0] rd_val;
   logic        next_rvalid;

   assign rd_idx = s_axi_araddr[9:2];
   assign next_rvalid = (s_axi_arvalid && s_axi_arready) ||
                        (s_axi_rvalid && !s_axi_rready);

   always_comb begin
      rd_val = '0;
      for (int c = 0; c < NCH; c++) begin
         if (rd_idx == tfdc_pkg::IDX_OP[c]) rd_val[7:0] = cfg[c].op;
         if (rd_idx == tfdc_pkg::IDX_LOW[c]) rd_val[7:0] = cfg[c].low;
         if (rd_idx == tfdc_pkg::IDX_HIGH[c]) rd_val[7:0] = cfg[c].high;
         if (rd_idx == tfdc_pkg::IDX_CRIT[c]) rd_val[7:0] = cfg[c].crit;
         if (rd_idx == tfdc_pkg::IDX_THR[c]) rd_val[7:0] = cfg[c].thr;
         if (rd_idx == tfdc_pkg::IDX_FLOOR[c]) rd_val[7:0] = cfg[c].floor;
         if (rd_idx == tfdc_pkg::IDX_CEIL[c]) rd_val[7:0] = cfg[c].ceil;
         if (rd_idx == tfdc_pkg::IDX_SPAN[c]) begin
            rd_val[tfdc_pkg::SPAN_LSB +: 4] = cfg[c].span;
         end
      end
      if (rd_idx == tfdc_pkg::IDX_HYST_A) begin
         rd_val[tfdc_pkg::HYST_HI_LSB +: 4] = cfg[0].hyst;
         rd_val[tfdc_pkg::HYST_LO_LSB +: 4] = cfg[1].hyst;
      end
      if (rd_idx == tfdc_pkg::IDX_HYST_B) begin
         rd_val[tfdc_pkg::HYST_HI_LSB +: 4] = cfg[2].hyst;
      end
      if (rd_idx == tfdc_pkg::IDX_IDLE) rd_val[7:0] = idle_policy;
      if (rd_idx == tfdc_pkg::IDX_CTRL) rd_val[7:0] = ctrl;
      if (rd_idx == tfdc_pkg::IDX_STAT) begin
         rd_val[tfdc_pkg::STAT_LOW_LSB +: NCH] = stat_low;
         rd_val[tfdc_pkg::STAT_HIGH_LSB +: NCH] = stat_high;
         rd_val[tfdc_pkg::STAT_CRIT_LSB +: NCH] = crit_on;
         rd_val[tfdc_pkg::STAT_ON_LSB +: NCH] = fan_on;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= tfdc_pkg::RESP_OKAY;
      end else begin
         s_axi_rvalid <= next_rvalid;
         s_axi_arready <= !next_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= rd_val;
            s_axi_rresp <= idx_mapped(rd_idx) ? tfdc_pkg::RESP_OKAY
                                              : tfdc_pkg::RESP_SLVERR;
         end
      end
   end

   // ---------------------------------------------------------------
   // monitoring tick and pwm carrier
   // ---------------------------------------------------------------
   assign tick = (mon_cnt == CNT_W'(MON_CYCLES - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mon_cnt <= '0;
      end else begin
         mon_cnt <= tick ? '0 : mon_cnt + 1'b1;
      end
   end

   // period of 255 counts so a duty of 255 never goes low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_cnt <= '0;
      end else begin
         pwm_cnt <= (pwm_cnt == tfdc_pkg::PWM_TOP) ? '0 : pwm_cnt + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // per-channel temperature control
   // ---------------------------------------------------------------
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      logic [7:0]         excess;
      logic [17:0]        prod;
      logic [17:0]        step;
      logic [18:0]        sum;
      logic [7:0]         slope_duty;
      logic signed [9:0]  t_s;
      logic signed [9:0]  off_lvl;
      logic signed [9:0]  rel_lvl;

      always_comb begin
         t_s = $signed({2'b00, temp[g]});
         off_lvl = $signed({2'b00, cfg[g].thr}) - $signed({6'h00, cfg[g].hyst});
         rel_lvl = $signed({2'b00, cfg[g].crit}) - $signed({6'h00, cfg[g].hyst});
         excess = (temp[g] > cfg[g].thr) ? temp[g] - cfg[g].thr : '0;
         // fixed slope of 170 counts per span
         prod = 18'(excess) * tfdc_pkg::SLOPE_NUM;
         step = prod / 18'(tfdc_pkg::SPAN_X6[cfg[g].span]);
         // floor plus slope, capped at ceiling
         sum = 19'(cfg[g].floor) + 19'(step);
         slope_duty = (sum > 19'(cfg[g].ceil)) ? cfg[g].ceil : sum[7:0];
      end

      assign below_low[g] = temp[g] < cfg[g].low;
      assign above_high[g] = temp[g] > cfg[g].high;
      assign thr_dec[g] = above_high[g] || (temp[g] > cfg[g].op);
      // raise only inside op point and high limit
      assign thr_inc[g] = below_low[g] && (cfg[g].thr < cfg[g].high) &&
                          (cfg[g].thr < cfg[g].op) && (temp[g] > cfg[g].thr);

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            fan_on[g] <= 1'b0;
            crit_on[g] <= 1'b0;
         end else begin
            // fan stays on inside the band
            if (temp[g] > cfg[g].thr) begin
               fan_on[g] <= 1'b1;
            end else if (t_s < off_lvl) begin
               fan_on[g] <= 1'b0;
            end
            if (temp[g] > cfg[g].crit) begin
               crit_on[g] <= 1'b1;
            end else if (t_s < rel_lvl) begin
               crit_on[g] <= 1'b0;
            end
         end
      end

      always_comb begin
         if (|crit_on) begin
            duty[g] = tfdc_pkg::DUTY_FULL;
         end else if (fan_on[g]) begin
            duty[g] = slope_duty;
         end else if (idle_policy[tfdc_pkg::IDLE_LSB + g]) begin
            duty[g] = cfg[g].floor;
         end else begin
            duty[g] = '0;
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pwm_q[g] <= 1'b0;
         end else begin
            pwm_q[g] <= pwm_cnt < duty[g];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         critical_active <= 1'b0;
      end else begin
         critical_active <= |crit_on;
      end
   end

   assign fan_out_1 = pwm_q[0];
   assign fan_out_2 = pwm_q[1];
   assign fan_out_3 = pwm_q[2];
endmodule : tfdc_top
`default_nettype wire

/* File: testbench/tfdc_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module tfdc_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_arvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        fan_out_1,
   input wire logic        fan_out_2,
   input wire logic        fan_out_3,
   input wire logic        critical_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ---------------------------------------------
   // register bus
   // ---------------------------------------------
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
   a_rd_latency: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_aw_block: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_rdata_top: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0)
      else $error("upper read bits set");
   // ---------------------------------------------
   // fan outputs
   // ---------------------------------------------
   a_crit_full: assert property (
      critical_active && $past(critical_active)
      |-> fan_out_1 && fan_out_2 && fan_out_3) else $error("fan low in crit");
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn
      |=> !fan_out_1 && !fan_out_2 && !fan_out_3 && !critical_active)
      else $error("outputs active after reset");
endmodule : tfdc_checker
`default_nettype wire

/* File: testbench/tfdc_fan_model.sv */
`timescale 1ns/1ns
`default_nettype none
// counts high cycles per fan over each successive 255-cycle window; a steady
// pwm of duty d then reads d, and full duty reads 255
module tfdc_fan_model (
   input wire logic         aclk,
   input wire logic         aresetn,
   input wire logic         fan_out_1,
   input wire logic         fan_out_2,
   input wire logic         fan_out_3,
   output logic [26:0]      duty_seen,
   output logic             win_done
);
   logic [7:0] win;
   logic [8:0] acc [3];
   logic [2:0] f;
   assign f = {fan_out_3, fan_out_2, fan_out_1};
   always_ff @(posedge aclk) begin
      if (!aresetn) win <= 8'h00;
      else win <= (win == 8'hfe) ? 8'h00 : win + 8'h01;
      win_done <= aresetn && (win == 8'hfe);
   end
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 3; i++) begin
         if (win == 8'hfe) begin
            duty_seen[i*9 +: 9] <= acc[i] + 9'(f[i]);
            acc[i] <= 9'h000;
         end else begin
            acc[i] <= acc[i] + 9'(f[i]);
         end
      end
   end
endmodule : tfdc_fan_model
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, fan_out_1, fan_out_2, fan_out_3, critical_active;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] temp_remote1 = 8'h10, temp_local = 8'h10, temp_remote2 = 8'h10;
   logic [26:0] duty_seen;
   logic win_done;
   logic [31:0] rd;
   int err_count = 0, checks_done = 0;
   always #50 aclk = ~aclk;
   tfdc_top #(.MON_CYCLES(16)) u_tfdc_top (.*);
   tfdc_fan_model u_tfdc_fan_model (.aclk, .aresetn, .fan_out_1, .fan_out_2,
      .fan_out_3, .duty_seen, .win_done);
   // ---------------------------------------------
   // reporting
   // ---------------------------------------------
   task automatic conclude;
      if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic miss(input string m);
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
   endtask : miss
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) miss($sformatf("value %h want %h", g, e));
   endtask : chk_reg
   task automatic chk_duty(input logic [26:0] g, input logic [26:0] e);
      checks_done++;
      if (g !== e) miss($sformatf("duty %h want %h", g, e));
   endtask : chk_duty
   // ---------------------------------------------
   // bus and stimulus helpers
   // ---------------------------------------------
   task automatic wr(input logic [7:0] i, input logic [7:0] d,
                     input logic [1:0] er = tfdc_pkg::RESP_OKAY);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 40) begin miss("write hang"); conclude(); end
      chk_reg(32'(s_axi_bresp), 32'(er));
   endtask : wr
   task automatic rd_chk(input logic [7:0] i, input logic [31:0] e,
                         input logic [1:0] er, input bit cmp = 1'b1);
      int n;
      @(posedge aclk);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 40) begin miss("read hang"); conclude(); end
      rd = s_axi_rdata;
      if (cmp) chk_reg(s_axi_rdata, e);
      chk_reg(32'(s_axi_rresp), 32'(er));
   endtask : rd_chk
   task automatic temps(input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] c);
      @(posedge aclk);
      temp_remote1 <= a;
      temp_local <= b;
      temp_remote2 <= c;
   endtask : temps
   // second full window lies wholly after the last change
   task automatic duty(input logic [8:0] e1, input logic [8:0] e2,
                       input logic [8:0] e3);
      int n;
      // let a temperature change reach the pwm flops before windowing
      repeat (3) @(posedge aclk);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin @(posedge aclk); n++; end
         while (win_done !== 1'b1 && n < 600);
         if (n >= 600) begin miss("no duty window"); conclude(); end
      end
      chk_duty(duty_seen, {e3, e2, e1});
   endtask : duty
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_regs;
      logic [7:0] ix [9] = '{8'h33, 8'h34, 8'h35, 8'h6a, 8'h6b, 8'h6c,
                             8'h6d, 8'h6e, 8'h62};
      logic [7:0] ev [9] = '{8'ha4, 8'ha4, 8'ha4, 8'ha4, 8'ha4, 8'ha4,
                             8'h44, 8'h40, 8'h00};
      for (int i = 0; i < 9; i++) rd_chk(ix[i], {24'h0, ev[i]}, 2'h0);
      rd_chk(8'h01, 32'h0, tfdc_pkg::RESP_SLVERR);
      wr(8'h01, 8'h5a, tfdc_pkg::RESP_SLVERR);
      wr(8'h6b, 8'h7e);
      rd_chk(8'h6b, 32'h7e, 2'h0);
      wr(8'h6b, 8'ha4);
   endtask : t_regs
   task automatic t_slope;
      wr(8'h73, 8'h00);
      wr(8'h70, 8'h30);
      wr(8'h64, 8'h55);
      wr(8'h5f, 8'hd0);
      temps(8'h44, 8'h10, 8'h10);
      duty(9'd170, 9'd0, 9'd0);
      temps(8'h58, 8'h10, 8'h10);
      duty(9'd255, 9'd0, 9'd0);
      wr(8'h64, 8'h80);
      temps(8'h4d, 8'h10, 8'h10);
      duty(9'd251, 9'd0, 9'd0);
      wr(8'h38, 8'hc0);
      temps(8'h58, 8'h10, 8'h10);
      duty(9'd192, 9'd0, 9'd0);
   endtask : t_slope
   task automatic t_hyst;
      temps(8'h2e, 8'h10, 8'h10);
      duty(9'd128, 9'd0, 9'd0);
      temps(8'h2b, 8'h10, 8'h10);
      duty(9'd0, 9'd0, 9'd0);
      wr(8'h62, 8'h20);
      temps(8'h31, 8'h10, 8'h10);
      duty(9'd132, 9'd0, 9'd0);
      temps(8'h2b, 8'h10, 8'h10);
      duty(9'd128, 9'd0, 9'd0);
   endtask : t_hyst
   task automatic t_crit;
      wr(8'h62, 8'h00);
      temps(8'h2b, 8'ha5, 8'h10);
      duty(9'd255, 9'd255, 9'd255);
      chk_reg(32'(critical_active), 32'h1);
      temps(8'h2b, 8'ha1, 8'h10);
      duty(9'd255, 9'd255, 9'd255);
      temps(8'h2b, 8'h9f, 8'h10);
      duty(9'd0, 9'd255, 9'd0);
      chk_reg(32'(critical_active), 32'h0);
      temps(8'h2b, 8'ha5, 8'h10);
      wr(8'h6d, 8'h42);
      temps(8'h2b, 8'ha1, 8'h10);
      duty(9'd0, 9'd255, 9'd0);
   endtask : t_crit
   task automatic t_idle;
      wr(8'h62, 8'he0);
      temps(8'h10, 8'h10, 8'h10);
      duty(9'd128, 9'd128, 9'd128);
      rd_chk(8'h62, 32'he0, 2'h0);
   endtask : t_idle
   task automatic t_dyn;
      wr(8'h35, 8'h20);
      wr(8'h53, 8'h30);
      wr(8'h4e, 8'h20);
      temps(8'h10, 8'h10, 8'h40);
      wr(8'h73, 8'h01);
      repeat (40) @(posedge aclk);
      wr(8'h73, 8'h00);
      rd_chk(8'h72, 32'h0, 2'h0, 1'b0);
      chk_reg({31'h0, rd[7:0] < 8'h5a}, 32'h1);
      rd_chk(8'h74, 32'h31, 2'h0);
      wr(8'h74, 8'h31);
      rd_chk(8'h74, 32'h21, 2'h0);
   endtask : t_dyn
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_slope();
      t_hyst();
      t_crit();
      t_idle();
      t_dyn();
      conclude();
   end
endmodule : tb
bind tfdc_top tfdc_checker u_tfdc_checker (.*);
`default_nettype wire
